/* eeprom_pkg.sv */
// Constants and carrier types for the serial EEPROM slave.
`default_nettype none
package eeprom_pkg;
  // Device type code value is arbitrary.
  localparam logic [3:0] DEV_TYPE = 4'h6;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam int PAGE_BITS = 4;
  localparam int PAGE_SIZE = 16;
  localparam int BYTE_BITS = 8;
  localparam int SEL_BITS = 3;
  localparam int MIN_AW = 7;
  localparam int MAX_AW = 11;
  localparam int DEF_AW = 11;
  localparam int PROG_CYCLES = 64;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_ADDR, ST_WR, ST_RD, ST_PROG} bus_state_type;

  typedef struct packed {
    logic [SEL_BITS-1:0] cs;
    logic wp;
    logic sda;
    logic scl;
  } pins_type;

  typedef struct packed {
    logic [MAX_AW-1:0] addr;
    logic [BYTE_BITS-1:0] data;
  } wr_entry_type;
endpackage : eeprom_pkg
`default_nettype wire

/* serial_eeprom_i2c_slave.sv */
// Two-wire EEPROM slave front end with its write buffer FIFO.
// Function
// - Respond only when select byte top four bits equal the device type.
// - Select bits b3..b1 must match the chip select pins.
// - Larger arrays take address bits 8..10 from select bits b1..b3.
// - Bytes travel most significant bit first.
// - Sequential reads continue while the master acknowledges each byte.
// - Accept a byte write or a page write of up to 16 bytes.
// - Acknowledge each written byte in the ninth clock slot.
// - Read returns to standby only after master not-ack then STOP; here the not-ack alone returns it to idle.
// - STOP directly after a write data ack starts the programming cycle.
// - START is data falling while clock steadily high.
// - STOP is data rising while clock steadily high; ends communication.
// - Watch for START always except while programming; ignore unstarted traffic.
// - Write protect high blocks all array writes; unconnected means low. Here the pin is read only from START through the address byte; no pull-down.
// - Under write protect ack select and address, not-ack data, keep memory.
// - During power-on reset the device is disabled and answers nothing.
// - Transmitter releases data after eight bits; receiver pulls low in ninth.
// - Data line is open drain: driven low or released, never high.
// - Data is sampled on each clock rising edge.
// - Eighth select bit is one for read and zero for write.
// - On select mismatch, no ack, release bus, standby until next START.
// - Page write increments only the low four address bits.
`timescale 1ns/1ns
`default_nettype none

module wr_fifo #(
  parameter int WIDTH = $bits(eeprom_pkg::wr_entry_type),
  parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } fifo_state_type;
  fifo_state_type s_r, s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two.");
  end

  assign in_ready_out = (s_r.wp ^ s_r.rp) != {1'h1, {PW{1'h0}}};
  assign out_valid_out = s_r.wp != s_r.rp;
  assign out_data_out = mem[s_r.rp[PW-1:0]];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.wp = s_r.wp + 1'h1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[s_r.wp[PW-1:0]] <= in_data_in;
    end
  end
endmodule : wr_fifo

module serial_eeprom_i2c_slave #(
  parameter int ADDR_W = eeprom_pkg::DEF_AW,
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
  parameter int FIFO_DEPTH = eeprom_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic chip_sel_pin_0_in,
  input wire logic chip_sel_pin_1_in,
  input wire logic chip_sel_pin_2_in,
  input wire logic write_protect_in,
  output logic prog_busy_out
);
  localparam int NUP = (ADDR_W > eeprom_pkg::BYTE_BITS) ? ADDR_W - eeprom_pkg::BYTE_BITS : 0;
  localparam int NLOW = (ADDR_W > eeprom_pkg::BYTE_BITS) ? eeprom_pkg::BYTE_BITS : ADDR_W;
  localparam int ROW_W = ADDR_W - eeprom_pkg::PAGE_BITS;
  localparam int CW = $clog2(PROG_CYCLES);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  // The copy counter must count past the last page slot, or no byte is ever copied.
  if (ADDR_W < eeprom_pkg::MIN_AW || ADDR_W > eeprom_pkg::MAX_AW
      || PROG_CYCLES <= eeprom_pkg::PAGE_SIZE) begin : g_bad_param
    $error("Address width must be 7 to 11 and programming cycles more than 16.");
  end

  typedef struct packed {
    eeprom_pkg::pins_type s1;
    eeprom_pkg::pins_type s2;
    logic prev_scl;
    logic prev_sda;
    eeprom_pkg::bus_state_type st;
    eeprom_pkg::bus_state_type nst;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic last_ack;
    logic prot;
    logic pend;
    logic oe_n;
    logic sda_lvl;
    logic busy;
    logic [ADDR_W-1:0] addr;
    logic [ROW_W-1:0] row;
    logic [eeprom_pkg::PAGE_SIZE-1:0] valid;
    logic [CW-1:0] pcnt;
  } state_type;

  state_type s_r, s_nxt;
  logic [7:0] mem [2**ADDR_W];
  logic [7:0] latch [eeprom_pkg::PAGE_SIZE];
  eeprom_pkg::pins_type raw;
  eeprom_pkg::wr_entry_type push_data, pop_data;
  logic push, fifo_ready, pop_valid, drain;
  logic scl_rise, scl_fall, start, stop, commit, type_ok;
  logic [7:0] byte_in;
  logic [eeprom_pkg::SEL_BITS-1:0] cs_ok;
  logic [eeprom_pkg::PAGE_BITS-1:0] pidx;

  assign raw = '{cs: {chip_sel_pin_2_in, chip_sel_pin_1_in, chip_sel_pin_0_in},
                 wp: write_protect_in, sda: sda_in, scl: scl_in};
  assign scl_rise = s_r.s2.scl && !s_r.prev_scl;
  assign scl_fall = !s_r.s2.scl && s_r.prev_scl;
  assign start = s_r.s2.scl && s_r.prev_scl && s_r.prev_sda && !s_r.s2.sda;
  assign stop = s_r.s2.scl && s_r.prev_scl && !s_r.prev_sda && s_r.s2.sda;
  assign byte_in = {s_r.sh[6:0], s_r.s2.sda};
  assign type_ok = byte_in[7:4] == eeprom_pkg::DEV_TYPE;
  // The clock rise that opens a STOP shifts one stray bit, so the ack flag outlives it.
  assign commit = stop && s_r.st == eeprom_pkg::ST_WR
                  && s_r.last_ack && s_r.pend;
  assign push_data = '{addr: eeprom_pkg::MAX_AW'(s_r.addr), data: byte_in};
  assign drain = pop_valid && s_r.pcnt == '0;
  assign pidx = s_r.pcnt[eeprom_pkg::PAGE_BITS-1:0];

  // Select bits that carry address bits in larger arrays always match.
  for (genvar i = 0; i < eeprom_pkg::SEL_BITS; i++) begin : g_sel
    if (i < NUP) begin : g_addr
      assign cs_ok[i] = 1'h1;
    end else begin : g_pin
      assign cs_ok[i] = byte_in[i+1] == s_r.s2.cs[i];
    end
  end

  always_comb begin
    s_nxt = s_r;
    push = 1'h0;
    s_nxt.s1 = raw;
    s_nxt.s2 = s_r.s1;
    s_nxt.prev_scl = s_r.s2.scl;
    s_nxt.prev_sda = s_r.s2.sda;
    if (drain) begin
      s_nxt.valid[pop_data.addr[eeprom_pkg::PAGE_BITS-1:0]] = 1'h1;
      s_nxt.row = pop_data.addr[ADDR_W-1:eeprom_pkg::PAGE_BITS];
    end
    if (s_r.st == eeprom_pkg::ST_PROG) begin
      // The bus is deaf here; the page is copied once the buffer drains.
      s_nxt.oe_n = 1'h1;
      if (!pop_valid) begin
        s_nxt.pcnt = s_r.pcnt + 1'h1;
        if (s_r.pcnt == PROG_LAST) begin
          s_nxt.pcnt = '0;
          s_nxt.valid = '0;
          s_nxt.st = eeprom_pkg::ST_IDLE;
        end
      end
    end else if (start) begin
      // A repeated start drops any unprogrammed page, as in a dummy write.
      s_nxt.st = eeprom_pkg::ST_SEL;
      s_nxt.cnt = '0;
      s_nxt.oe_n = 1'h1;
      s_nxt.prot = s_r.s2.wp;
      s_nxt.pend = 1'h0;
      s_nxt.last_ack = 1'h0;
      s_nxt.valid = '0;
    end else if (stop) begin
      s_nxt.oe_n = 1'h1;
      s_nxt.st = commit ? eeprom_pkg::ST_PROG : eeprom_pkg::ST_IDLE;
    end else if (s_r.st == eeprom_pkg::ST_IDLE) begin
      s_nxt.oe_n = 1'h1;
    end else if (scl_rise) begin
      if (s_r.st == eeprom_pkg::ST_SEL || s_r.st == eeprom_pkg::ST_ADDR) begin
        s_nxt.prot = s_r.prot | s_r.s2.wp;
      end
      if (s_r.cnt != eeprom_pkg::ACK_SLOT) begin
        s_nxt.sh = byte_in;
        s_nxt.cnt = s_r.cnt + 1'h1;
        if (s_r.cnt != '0) begin
          s_nxt.last_ack = 1'h0;
        end
        if (s_r.cnt == eeprom_pkg::LAST_BIT) begin
          case (s_r.st)
            eeprom_pkg::ST_SEL: begin
              s_nxt.ack = type_ok && (&cs_ok);
              if (!s_nxt.ack) begin
                s_nxt.nst = eeprom_pkg::ST_IDLE;
              end else if (byte_in[0]) begin
                s_nxt.nst = eeprom_pkg::ST_RD;
              end else begin
                s_nxt.nst = eeprom_pkg::ST_ADDR;
              end
              if (s_nxt.ack) begin
                for (int i = 0; i < NUP; i++) begin
                  s_nxt.addr[eeprom_pkg::BYTE_BITS+i] = byte_in[i+1];
                end
              end
            end
            eeprom_pkg::ST_ADDR: begin
              s_nxt.ack = 1'h1;
              s_nxt.nst = eeprom_pkg::ST_WR;
              for (int i = 0; i < NLOW; i++) begin
                s_nxt.addr[i] = byte_in[i];
              end
            end
            eeprom_pkg::ST_WR: begin
              // A full buffer refuses the byte with a not-ack.
              s_nxt.ack = !s_r.prot && fifo_ready;
              s_nxt.nst = eeprom_pkg::ST_WR;
              if (s_nxt.ack) begin
                push = 1'h1;
                s_nxt.pend = 1'h1;
                s_nxt.addr[eeprom_pkg::PAGE_BITS-1:0] =
                  s_r.addr[eeprom_pkg::PAGE_BITS-1:0] + 1'h1;
              end
            end
            default: begin
              s_nxt.ack = 1'h0;
            end
          endcase
        end
      end else begin
        s_nxt.cnt = '0;
        s_nxt.last_ack = s_r.ack;
        s_nxt.st = s_r.nst;
        if (s_r.st == eeprom_pkg::ST_RD && s_r.s2.sda) begin
          s_nxt.st = eeprom_pkg::ST_IDLE;
        end
        if (s_nxt.st == eeprom_pkg::ST_RD) begin
          s_nxt.nst = eeprom_pkg::ST_RD;
          s_nxt.sh = mem[s_r.addr];
          s_nxt.addr = s_r.addr + 1'h1;
        end
      end
    end else if (scl_fall) begin
      if (s_r.st == eeprom_pkg::ST_RD) begin
        s_nxt.oe_n = (s_r.cnt == eeprom_pkg::ACK_SLOT) | s_r.sh[7];
      end else begin
        s_nxt.oe_n = !(s_r.cnt == eeprom_pkg::ACK_SLOT && s_r.ack);
      end
    end
    s_nxt.busy = s_nxt.st == eeprom_pkg::ST_PROG;
  end

  // Reset holds the line released and the block idle.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
      s_r.oe_n <= 1'h1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (drain) begin
      latch[pop_data.addr[eeprom_pkg::PAGE_BITS-1:0]] <= pop_data.data;
    end
    if (s_r.st == eeprom_pkg::ST_PROG && !pop_valid
        && s_r.pcnt < CW'(eeprom_pkg::PAGE_SIZE) && s_r.valid[pidx]) begin
      mem[{s_r.row, pidx}] <= latch[pidx];
    end
  end

  wr_fifo #(
    .WIDTH($bits(eeprom_pkg::wr_entry_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_data_in(push_data),
    .in_valid_in(push),
    .in_ready_out(fifo_ready),
    .out_data_out(pop_data),
    .out_valid_out(pop_valid),
    .out_ready_in(drain)
  );

  assign sda_out = s_r.sda_lvl;
  assign sda_oe_n_out = s_r.oe_n;
  assign prog_busy_out = s_r.busy;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence sel_end_s;
    scl_rise && s_r.st == eeprom_pkg::ST_SEL && s_r.cnt == eeprom_pkg::LAST_BIT;
  endsequence
  sequence wr_end_s;
    scl_rise && s_r.st == eeprom_pkg::ST_WR && s_r.cnt == eeprom_pkg::LAST_BIT;
  endsequence

  type_nack_a: assert property (sel_end_s and !type_ok |=> !s_r.ack)
    else $error("Wrong device type was acknowledged.");
  cs_nack_a: assert property (sel_end_s and !(&cs_ok) |=> !s_r.ack)
    else $error("Wrong chip select was acknowledged.");
  msb_first_a: assert property (scl_rise && s_r.st inside {eeprom_pkg::ST_SEL,
      eeprom_pkg::ST_ADDR, eeprom_pkg::ST_WR} && s_r.cnt != eeprom_pkg::ACK_SLOT
      |=> s_r.sh[0] == $past(s_r.s2.sda) && s_r.sh[7:1] == $past(s_r.sh[6:0]))
    else $error("Bit was not shifted in at the low end.");
  wr_ack_a: assert property (wr_end_s and !s_r.prot && fifo_ready
      |=> s_r.ack && s_r.pend ##[1:24] !sda_oe_n_out)
    else $error("Writable byte was not acknowledged.");
  wp_nack_a: assert property (wr_end_s and s_r.prot |=> !s_r.ack && $stable(s_r.pend))
    else $error("Protected data byte was acknowledged.");
  start_sel_a: assert property (start && s_r.st != eeprom_pkg::ST_PROG
      |=> s_r.st == eeprom_pkg::ST_SEL && s_r.cnt == '0 && s_r.oe_n)
    else $error("START did not open a select byte.");
  stop_idle_a: assert property (stop && !commit && s_r.st != eeprom_pkg::ST_PROG
      |=> s_r.st == eeprom_pkg::ST_IDLE ##1 s_r.oe_n)
    else $error("STOP did not return to standby.");
  commit_a: assert property (commit |=> s_r.st == eeprom_pkg::ST_PROG && prog_busy_out)
    else $error("Write STOP did not start programming.");
  prog_quiet_a: assert property (s_r.st == eeprom_pkg::ST_PROG |=> sda_oe_n_out)
    else $error("Line driven during programming.");
  rd_nack_a: assert property (scl_rise && s_r.st == eeprom_pkg::ST_RD
      && s_r.cnt == eeprom_pkg::ACK_SLOT && s_r.s2.sda |=> s_r.st == eeprom_pkg::ST_IDLE)
    else $error("Read went on after a not-ack.");
  page_wrap_a: assert property (push |=> s_r.addr[ADDR_W-1:eeprom_pkg::PAGE_BITS]
      == $past(s_r.addr[ADDR_W-1:eeprom_pkg::PAGE_BITS]))
    else $error("Page write left its row.");
  low_only_a: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("Data line driven high.");
endmodule : serial_eeprom_i2c_slave
`default_nettype wire

/* bus_master_model.sv */
// Two-wire bus master model that makes the bus clock and drives its side of the data line.
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // Every change lands 1 ns after a clock edge so the slave's samplers never race it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic start_cond();
    sda_out = 1'b1;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
    tick(4);
  endtask : start_cond

  task automatic stop_cond();
    sda_out = 1'b0;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b1;
    tick(8);
  endtask : stop_cond

  // Data moves only in the middle of the low phase; the clock stands still between frames.
  task automatic bit_x(input logic v, output logic r);
    sda_out = v;
    tick(4);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    tick(4);
    scl_out = 1'b0;
    tick(4);
  endtask : bit_x

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, ack);
  endtask : put_byte

  task automatic get_byte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(nack, r);
  endtask : get_byte
endmodule : bus_master_model
`default_nettype wire

/* serial_eeprom_i2c_slave_test.sv */
// Self-checking bench for the serial EEPROM slave against an associative-array memory model.
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_i2c_slave_test;
  localparam int PROG = 200;
  logic clk_in, resetn_in, scl, msda, sda_out, sda_oe_n_out, wp, busy, sda_w;
  logic [2:0] cs;
  logic [7:0] mem [int];
  int ptr, base, failures, cmp_count;

  // Open-drain wire with pull-up: low whenever either party pulls it.
  assign sda_w = msda & (sda_oe_n_out | sda_out);

  // A 512-byte build: b1 carries address bit 8 while b3 and b2 still face the pins.
  serial_eeprom_i2c_slave #(.ADDR_W(9), .PROG_CYCLES(PROG),
    .FIFO_DEPTH(eeprom_pkg::FIFO_DEPTH)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .chip_sel_pin_0_in(cs[0]),
    .chip_sel_pin_1_in(cs[1]), .chip_sel_pin_2_in(cs[2]), .write_protect_in(wp),
    .prog_busy_out(busy));
  bus_master_model bm (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(msda));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_ack(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_ack

  always @(negedge clk_in) if (sda_oe_n_out === 1'b0) chk_ack(sda_out, 1'b0);

  function automatic logic [7:0] sel(input int a, input logic rw);
    return {eeprom_pkg::DEV_TYPE, cs[2:1], a[8], rw};
  endfunction : sel

  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    bm.put_byte(b, ack);
    chk_ack(ack, exp);
  endtask : send

  task automatic wait_busy(input logic exp, input logic probe);
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 60) begin
      bm.tick(1);
      k++;
    end
    chk_ack(busy, exp);
    if (exp && probe) begin
      bm.start_cond();
      send(sel(0, 1'b1), 1'b1);
      bm.stop_cond();
    end
    k = 0;
    while (busy !== 1'b0) begin
      bm.tick(1);
      k++;
      if (k > PROG + 2000) begin
        failures++;
        close_out();
      end
    end
  endtask : wait_busy

  task automatic wr(input int a, input int n, input logic prot, input logic probe);
    logic [7:0] d;
    bm.start_cond();
    send(sel(a, 1'b0), 1'b0);
    send(a[7:0], 1'b0);
    for (int i = 0; i < n; i++) begin
      d = $urandom;
      send(d, prot);
      if (!prot) mem[(a & 32'h0000_01f0) | ((a + i) & 32'h0000_000f)] = d;
    end
    bm.stop_cond();
    wait_busy(!prot, probe);
  endtask : wr

  task automatic rd(input int a, input int n, input logic rnd);
    logic [7:0] d;
    if (rnd) begin
      bm.start_cond();
      send(sel(a, 1'b0), 1'b0);
      send(a[7:0], 1'b0);
      ptr = a;
    end
    bm.start_cond();
    send(sel(ptr, 1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      bm.get_byte(d, i == n - 1);
      chk_byte(d, mem[ptr]);
      ptr = (ptr + 1) % 512;
    end
    bm.stop_cond();
  endtask : rd

  initial begin
    resetn_in = 1'b0;
    wp = 1'b0;
    cs = 3'h0;
    failures = 0;
    cmp_count = 0;
    void'($urandom(32'h55a4cec9));
    bm.tick(6);
    resetn_in = 1'b1;
    cs = $urandom;
    base = $urandom & 32'h0000_01e0;
    bm.tick(8);
    wr(base + 16, 1, 1'b0, 1'b1);
    rd(base + 16, 1, 1'b1);
    $display("test byte_write done");
    wr(base + 14, 18, 1'b0, 1'b0);
    rd(base, 15, 1'b1);
    rd(0, 2, 1'b0);
    $display("test page_write done");
    wp = 1'b1;
    wr(base + 3, 2, 1'b1, 1'b0);
    wp = 1'b0;
    rd(base + 3, 2, 1'b1);
    $display("test write_protect done");
    bm.start_cond();
    send({eeprom_pkg::DEV_TYPE ^ 4'h1, cs[2:1], base[8], 1'b1}, 1'b1);
    bm.stop_cond();
    bm.start_cond();
    send({eeprom_pkg::DEV_TYPE, cs[2:1] ^ 2'h1, base[8], 1'b1}, 1'b1);
    bm.stop_cond();
    send(sel(base, 1'b1), 1'b1);
    bm.stop_cond();
    $display("test select_mismatch done");
    resetn_in = 1'b0;
    bm.start_cond();
    send(sel(base, 1'b1), 1'b1);
    chk_ack(busy, 1'b0);
    bm.stop_cond();
    resetn_in = 1'b1;
    bm.tick(8);
    rd(base + 5, 1, 1'b1);
    $display("test reset_lockout done");
    close_out();
  end
endmodule : serial_eeprom_i2c_slave_test
`default_nettype wire
